// file: src/lcs_pkg.sv
// Package with constants and types for the light control channel and startup block.
package lcs_pkg;

  localparam int unsigned CLK_HZ       = 10000000;
  localparam int unsigned MAX_CHANNELS = 3;
  localparam logic [7:0]  OUT_MAX      = 8'hFF;
  localparam logic [7:0]  OUT_OFF      = 8'h00;
  localparam logic [7:0]  PCT_UNITY    = 8'h64;
  localparam logic [3:0]  DIM_STOP     = 4'h0;
  localparam logic [3:0]  DIM_UP_BIT   = 4'h8;
  localparam logic [15:0] RESET_COUNT  = 16'h0000;
  localparam logic [7:0]  RESET_OUT    = 8'h00;

  // Base of the waiting and repeat timers: one tick every 1 ms.
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned TICK_CYCLES  = (CLK_HZ / 1000) * TICK_MS;
  localparam logic [15:0] TICK_LAST    = 16'(TICK_CYCLES - 1);

  typedef enum logic [1:0]
  {
    LCS_OFS_FIXED = 2'h0,
    LCS_OFS_RISE  = 2'h1,
    LCS_OFS_FALL  = 2'h2
  } lcs_ofs_t;

  typedef enum logic [1:0]
  {
    LCS_SU_SWITCH = 2'h0,
    LCS_SU_DIM    = 2'h1,
    LCS_SU_PRESET = 2'h2,
    LCS_SU_ADAPT  = 2'h3
  } lcs_su_t;

  typedef enum logic [5:0]
  {
    LCS_IDLE  = 6'h01,
    LCS_CHECK = 6'h02,
    LCS_DIM   = 6'h04,
    LCS_STOP  = 6'h08,
    LCS_WAIT  = 6'h10,
    LCS_MAIN  = 6'h20
  } lcs_state_t;

endpackage

// file: src/lcs_core.sv
// Channel offset derivation and startup control sequencing of the light controller.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - One to three channels, each its own output.
// - Several channels: only absolute byte values sent.
// - Channels two, three derived from channel one.
// - Offset method selects fixed, rising or decreasing.
// - Fixed method adds constant signed offset.
// - Channel one zero forces channels two, three zero.
// - On-off hysteresis on channels two, three for negatives.
// - Rising method scales by percentage, caps 255.
// - Percentage below/above hundred lowers/raises output.
// - Decreasing offset shrinks from start to sync.
// - At sync level offset becomes zero.
// - Brightness at setpoint goes straight to main.
// - Below setpoint runs configured startup behaviour.
// - Switch-on sends one switching telegram.
// - Switch and dimming only with one channel.
// - Brighten steps repeat until setpoint reached.
// - Stop telegram ends relative dimming.
// - Preset sends configured absolute value.
// - Adaptive value from brightness, setpoint, range.
// - Waiting timer runs after startup action, before main phase.
module lcs_core
  import lcs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Configuration
  input  wire logic [1:0]  chan_count,
  input  wire logic [1:0]  ofs_method,
  input  wire logic [7:0]  ofs_fixed_ch2,
  input  wire logic [7:0]  ofs_fixed_ch3,
  input  wire logic [8:0]  ofs_pct_ch2,
  input  wire logic [8:0]  ofs_pct_ch3,
  input  wire logic [7:0]  sync_lvl_ch2,
  input  wire logic [7:0]  sync_lvl_ch3,
  input  wire logic [7:0]  onoff_hyst,
  input  wire logic [1:0]  startup_mode,
  input  wire logic [2:0]  dim_step,
  input  wire logic [15:0] dim_repeat_ms,
  input  wire logic [7:0]  preset_value,
  input  wire logic [15:0] wait_ms,
  input  wire logic [15:0] range_lux,
  // Brightness and control
  input  wire logic [15:0] meas_lux,
  input  wire logic [15:0] setpoint_lux,
  input  wire logic        startup_req,
  input  wire logic [7:0]  ch1_ctrl,
  input  wire logic        ch1_ctrl_valid,
  // Switching output object
  output logic             sw_send,
  output logic             sw_value,
  // Relative dimming output object
  output logic             dim_send,
  output logic [3:0]       dim_code,
  // Brightness value output objects
  output logic             val_send,
  output logic [7:0]       val_ch1,
  output logic [7:0]       val_ch2,
  output logic [7:0]       val_ch3,
  // Phase status
  output logic             in_startup,
  output logic             in_main
);

  //////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  // Saturates a signed intermediate to the byte range instead of letting it wrap.
  function automatic logic [7:0] clamp_byte(input logic signed [17:0] v);
    if (v < 18'sd0)
      return OUT_OFF;
    else if (v > 18'sd255)
      return OUT_MAX;
    else
      return v[7:0];
  endfunction

  // Derives one channel's value from channel one; on_prev carries hysteresis state.
  function automatic logic [8:0] derive(
    input logic [1:0] meth,
    input logic [7:0] c1,
    input logic [7:0] fix,
    input logic [8:0] pct,
    input logic [7:0] sync,
    input logic [7:0] hyst,
    input logic       on_prev
  );
    logic signed [17:0] ofs;
    logic signed [17:0] raw;
    logic [16:0]        prod;
    logic [7:0]         res;
    logic               on;
    ofs  = 18'sd0;
    raw  = 18'sd0;
    prod = 17'h00000;
    res  = OUT_OFF;
    on   = on_prev;
    if (meth == LCS_OFS_RISE)
    begin
      prod = 17'(c1 * pct / PCT_UNITY);
      res  = (prod > 17'(OUT_MAX)) ? OUT_MAX : prod[7:0];
      on   = (c1 != OUT_OFF);
    end
    else if (c1 == OUT_OFF)
    begin
      res = OUT_OFF;
      on  = 1'b0;
    end
    else
    begin
      if (meth == LCS_OFS_FALL)
      begin
        // The division truncates toward zero, so a small start offset fades out early.
        if (c1 >= sync || sync <= 8'h01)
          ofs = 18'sd0;
        else
          ofs = 18'($signed({{10{fix[7]}}, fix}) * $signed({10'h000, sync - c1})
                / $signed({10'h000, sync - 8'h01}));
      end
      else
        ofs = 18'($signed({{10{fix[7]}}, fix}));
      raw = $signed({10'h000, c1}) + ofs;
      // A channel that would fall to zero is only re-enabled hyst above its cut-off.
      if (ofs < 18'sd0)
      begin
        if (raw > 18'sd0 + 18'($signed({10'h000, hyst})))
          on = 1'b1;
        else if (raw <= 18'sd0)
          on = 1'b0;
      end
      else
        on = 1'b1;
      res = on ? clamp_byte(raw) : OUT_OFF;
    end
    return {on, res};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    lcs_state_t  state;
    logic [15:0] tick;
    logic [15:0] timer;
    logic        ch2_on;
    logic        ch3_on;
    logic        sw_send;
    logic        sw_value;
    logic        dim_send;
    logic [3:0]  dim_code;
    logic        val_send;
    logic [7:0]  val_ch1;
    logic [7:0]  val_ch2;
    logic [7:0]  val_ch3;
    logic        val_dly;
  } lcs_regs_t;

  lcs_regs_t st_reg;
  lcs_regs_t st_next;

  logic       multi_ch;
  logic       below;
  logic       tick_hit;
  logic [1:0] eff_mode;
  logic [8:0] d2;
  logic [8:0] d3;
  logic [7:0] adapt_val;

  assign multi_ch = (chan_count > 2'h1);
  // Brightness exactly at the setpoint counts as reached, so no startup action is sent.
  assign below    = (meas_lux < setpoint_lux);
  // One shared millisecond prescaler paces both the repeat and the waiting timer.
  assign tick_hit = (st_reg.tick == TICK_LAST);
  // Switching and dimming are refused with several channels; preset is used instead.
  assign eff_mode = (multi_ch && (startup_mode == LCS_SU_SWITCH ||
                    startup_mode == LCS_SU_DIM)) ? LCS_SU_PRESET : startup_mode;

  assign d2 = derive(ofs_method, st_reg.val_ch1, ofs_fixed_ch2, ofs_pct_ch2,
                     sync_lvl_ch2, onoff_hyst, st_reg.ch2_on);
  assign d3 = derive(ofs_method, st_reg.val_ch1, ofs_fixed_ch3, ofs_pct_ch3,
                     sync_lvl_ch3, onoff_hyst, st_reg.ch3_on);

  // Lux deficit mapped onto the full output span of the brightness range.
  always_comb
  begin
    logic [31:0] q;
    q = 32'h00000000;
    // A range of zero cannot be scaled, so the full output is sent instead.
    if (range_lux == 16'h0000)
      adapt_val = OUT_MAX;
    else
    begin
      q = 32'(setpoint_lux - meas_lux) * 32'(OUT_MAX) / 32'(range_lux);
      adapt_val = (q > 32'(OUT_MAX)) ? OUT_MAX : q[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_next          = st_reg;
    st_next.sw_send  = 1'b0;
    st_next.dim_send = 1'b0;
    st_next.val_send = 1'b0;
    st_next.tick     = tick_hit ? RESET_COUNT : st_reg.tick + 16'h0001;
    if (st_reg.state == LCS_DIM || st_reg.state == LCS_WAIT)
    begin
      if (tick_hit && st_reg.timer != RESET_COUNT)
        st_next.timer = st_reg.timer - 16'h0001;
    end
    case (st_reg.state)
      LCS_IDLE:
      begin
        if (startup_req)
          st_next.state = LCS_CHECK;
      end
      LCS_CHECK:
      begin
        // Restarting the prescaler makes the first interval a full millisecond.
        st_next.tick = RESET_COUNT;
        if (!below)
          st_next.state = LCS_MAIN;
        else
        begin
          st_next.timer = wait_ms;
          st_next.state = LCS_WAIT;
          case (eff_mode)
            LCS_SU_SWITCH:
            begin
              st_next.sw_send  = 1'b1;
              st_next.sw_value = 1'b1;
            end
            LCS_SU_DIM:
            begin
              st_next.dim_send = 1'b1;
              st_next.dim_code = DIM_UP_BIT | {1'b0, dim_step};
              st_next.timer    = dim_repeat_ms;
              st_next.state    = LCS_DIM;
            end
            LCS_SU_PRESET:
            begin
              st_next.val_ch1  = preset_value;
              st_next.val_send = 1'b1;
            end
            default:
            begin
              st_next.val_ch1  = adapt_val;
              st_next.val_send = 1'b1;
            end
          endcase
        end
      end
      LCS_DIM:
      begin
        // Reaching the setpoint wins over a brighten step due in the same cycle.
        if (!below)
        begin
          st_next.dim_send = 1'b1;
          st_next.dim_code = DIM_STOP;
          st_next.state    = LCS_STOP;
        end
        else if (st_reg.timer == RESET_COUNT)
        begin
          st_next.dim_send = 1'b1;
          st_next.timer    = dim_repeat_ms;
          st_next.tick     = RESET_COUNT;
        end
      end
      LCS_STOP:
      begin
        st_next.timer = wait_ms;
        st_next.tick  = RESET_COUNT;
        st_next.state = LCS_WAIT;
      end
      LCS_WAIT:
      begin
        // A setpoint reached early does not shorten the settling time of the lamps.
        if (st_reg.timer == RESET_COUNT)
          st_next.state = LCS_MAIN;
      end
      LCS_MAIN:
      begin
        // A new startup request wins over a channel-one value in the same cycle.
        if (startup_req)
          st_next.state = LCS_CHECK;
        else if (ch1_ctrl_valid)
        begin
          st_next.val_ch1  = ch1_ctrl;
          st_next.val_send = 1'b1;
        end
      end
      default:
        st_next.state = LCS_IDLE;
    endcase
    // Derived channels follow the channel-one value that is already registered.
    st_next.ch2_on  = (chan_count >= 2'h2) && d2[8];
    st_next.ch3_on  = (chan_count >= 2'h3) && d3[8];
    st_next.val_ch2 = (chan_count >= 2'h2) ? d2[7:0] : OUT_OFF;
    st_next.val_ch3 = (chan_count >= 2'h3) ? d3[7:0] : OUT_OFF;
    // The value strobe lags channel one by a cycle so the derived channels agree.
    st_next.val_dly = st_reg.val_send;
  end

  // Reset clears every field except the phase, which loads LCS_IDLE; the codes are named for clarity.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg          <= '0;
      st_reg.state    <= LCS_IDLE;
      st_reg.dim_code <= DIM_STOP;
      st_reg.val_ch1  <= RESET_OUT;
    end
    else
      st_reg <= st_next;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Every output comes straight from a register; only the phase flags are decoded.
  assign sw_send    = st_reg.sw_send;
  assign sw_value   = st_reg.sw_value;
  assign dim_send   = st_reg.dim_send;
  assign dim_code   = st_reg.dim_code;
  assign val_send   = st_reg.val_dly;
  assign val_ch1    = st_reg.val_ch1;
  assign val_ch2    = st_reg.val_ch2;
  assign val_ch3    = st_reg.val_ch3;
  assign in_startup = (st_reg.state != LCS_IDLE) && (st_reg.state != LCS_MAIN);
  assign in_main    = (st_reg.state == LCS_MAIN);

endmodule

// file: dv/lcs_act.sv
// Lamp actuator model that answers the controller's telegrams.
`timescale 1ns/1ps

module lcs_act
  import lcs_pkg::*;
(
  // Clock and reset
  input logic        clk,
  input logic        srst,
  // Telegrams from the controller
  input logic        sw_send,
  input logic        sw_value,
  input logic        dim_send,
  input logic [3:0]  dim_code,
  input logic        val_send,
  input logic [7:0]  val_ch1,
  // Lamp level seen by the sensor
  output logic [7:0] act_level
);

  ////////////////////////////////////////
  // A brighten step adds only a quarter of the range, so several steps are needed.
  always_ff @(posedge clk)
    if (srst)
      act_level <= OUT_OFF;
    else if (sw_send)
      act_level <= sw_value ? OUT_MAX : OUT_OFF;
    else if (dim_send && dim_code[3])
      act_level <= (act_level > 8'hBF) ? OUT_MAX : act_level + 8'h40;
    else if (val_send)
      act_level <= val_ch1;

endmodule

// file: dv/lcs_core_sva.sv
// Assertions on the ports of the light controller core.
`timescale 1ns/1ps

module lcs_core_sva
  import lcs_pkg::*;
(
  // Clock, reset and settings
  input logic        clk,
  input logic        srst,
  input logic [1:0]  chan_count,
  input logic [1:0]  startup_mode,
  input logic [2:0]  dim_step,
  input logic [7:0]  preset_value,
  input logic [15:0] meas_lux,
  input logic [15:0] setpoint_lux,
  input logic        startup_req,
  // Outputs
  input logic        sw_send,
  input logic        sw_value,
  input logic        dim_send,
  input logic [3:0]  dim_code,
  input logic        val_send,
  input logic [7:0]  val_ch1,
  input logic [7:0]  val_ch2,
  input logic [7:0]  val_ch3,
  input logic        in_startup,
  input logic        in_main
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  wire sp_met = meas_lux >= setpoint_lux;

  ////////////////////////////////////////
  reset_quiet_a: assert property (disable iff (1'b0) srst |=> !in_startup && !in_main && !val_send)
    else $error("phase or send active after reset");
  multi_quiet_a: assert property (chan_count > 2'h1 |-> !sw_send && !dim_send)
    else $error("switch or dim telegram with several channels");
  zero_follow_a: assert property (val_send && val_ch1 == OUT_OFF |-> val_ch2 == 8'h00 && val_ch3 == 8'h00)
    else $error("derived channel on while channel one off");
  switch_on_a: assert property (sw_send |-> sw_value)
    else $error("switch telegram not on");
  dim_up_a: assert property (dim_send && dim_code != DIM_STOP |-> dim_code == (DIM_UP_BIT | {1'b0, dim_step}) && in_startup)
    else $error("brighten code wrong");
  dim_stop_a: assert property (dim_send && dim_code == DIM_STOP |-> $past(sp_met))
    else $error("stop sent below setpoint");
  direct_main_a: assert property (startup_req && !in_startup && sp_met |-> ##2 in_main)
    else $error("no direct main phase");
  start_act_a: assert property (startup_req && !in_startup && !sp_met |-> ##[1:3] (sw_send || dim_send || val_send))
    else $error("no startup telegram");
  wait_hold_a: assert property ($rose(val_send) && in_startup |=> !in_main [*8])
    else $error("main phase without waiting");
  preset_val_a: assert property (val_send && in_startup && startup_mode == LCS_SU_PRESET |-> val_ch1 == preset_value)
    else $error("preset value wrong");

  cover property (dim_send && dim_code == DIM_STOP);
  cover property (sw_send);
  cover property ($rose(in_main));

endmodule

bind lcs_core lcs_core_sva lcs_core_sva_inst (.*);

// file: dv/tb_light_control_channel_startup.sv
// Self-checking bench for channel derivation and startup sequencing.
`timescale 1ns/1ps

module tb_light_control_channel_startup
  import lcs_pkg::*;
  ;

  logic        clk, srst, startup_req, ch1_ctrl_valid, sw_send, sw_value, dim_send, val_send;
  logic        in_startup, in_main;
  logic [1:0]  chan_count, ofs_method, startup_mode;
  logic [7:0]  ofs_fixed_ch2, ofs_fixed_ch3, sync_lvl_ch2, sync_lvl_ch3, onoff_hyst;
  logic [7:0]  preset_value, ch1_ctrl, val_ch1, val_ch2, val_ch3, act_level;
  logic [8:0]  ofs_pct_ch2, ofs_pct_ch3;
  logic [2:0]  dim_step;
  logic [3:0]  dim_code;
  logic [15:0] dim_repeat_ms, wait_ms, range_lux, meas_lux, setpoint_lux;
  int          err_count, n_tests, cyc, n_sw, n_up, n_stop, n_val;
  bit          on2, on3, use_act;

  lcs_core lcs_core_inst (.*);
  lcs_act lcs_act_inst (.*);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(string what, int exp, logic [15:0] got);
    n_tests++;
    if (got !== 16'(exp))
    begin
      err_count++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  function automatic int derive(int c1, logic [7:0] ofs, logic [8:0] pct, logic [7:0] sy);
    if (c1 == 0)
      return 0;
    if (ofs_method == LCS_OFS_RISE)
      return c1 * int'(pct) / 100;
    if (ofs_method == LCS_OFS_FALL && c1 >= int'(sy))
      return c1;
    if (ofs_method == LCS_OFS_FALL)
      return c1 + int'($signed(ofs)) * (int'(sy) - c1) / (int'(sy) - 1);
    return c1 + int'($signed(ofs));
  endfunction

  // The on state is kept per channel; hysteresis guards only a negative offset.
  function automatic int hyst_out(int c1, int raw, ref bit on);
    if (ofs_method == LCS_OFS_RISE)
      on = (c1 != 0);
    else if (c1 == 0)
      on = 1'b0;
    else if (raw < c1)
      on = on ? raw > 0 : raw > int'(onoff_hyst);
    else
      on = 1'b1;
    return !on ? 0 : raw > 255 ? 255 : raw;
  endfunction

  task automatic chk_vals(int c1);
    int e2;
    int e3;
    e2 = hyst_out(c1, derive(c1, ofs_fixed_ch2, ofs_pct_ch2, sync_lvl_ch2), on2);
    e3 = hyst_out(c1, derive(c1, ofs_fixed_ch3, ofs_pct_ch3, sync_lvl_ch3), on3);
    chk("val_ch1", c1, val_ch1);
    chk("val_ch2", e2, val_ch2);
    chk("val_ch3", e3, val_ch3);
  endtask

  task automatic startup(int mode, int cc, int meas);
    int t;
    @(negedge clk);
    startup_mode = 2'(mode);
    chan_count = 2'(cc);
    if (!use_act)
      meas_lux = 16'(meas);
    n_sw = 0;
    n_up = 0;
    n_stop = 0;
    n_val = 0;
    startup_req = 1'b1;
    @(negedge clk);
    startup_req = 1'b0;
    chk("in_startup", 1, in_startup);
    for (t = 0; t < 25000 && in_main !== 1'b1; t++)
      @(negedge clk);
    chk("in_main", 1, in_main);
  endtask

  always @(negedge clk)
  begin
    if (use_act)
      meas_lux = {8'h00, act_level};
    if (sw_send === 1'b1 && sw_value === 1'b1)
      n_sw++;
    if (val_send === 1'b1)
      n_val++;
    if (dim_send === 1'b1 && dim_code === DIM_STOP)
      n_stop++;
    if (dim_send === 1'b1 && dim_code === (DIM_UP_BIT | {1'b0, dim_step}))
      n_up++;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////
  initial
  begin
    srst = 1'b1;
    {startup_req, ch1_ctrl_valid, ch1_ctrl, ofs_method, startup_mode} = '0;
    {chan_count, meas_lux, setpoint_lux, range_lux} = {2'h1, 16'h0000, 16'h0064, 16'h00C8};
    {dim_step, dim_repeat_ms, wait_ms, preset_value} = {3'h5, 16'h0001, 16'h0001, 8'hB4};
    {ofs_fixed_ch2, ofs_fixed_ch3, ofs_pct_ch2, ofs_pct_ch3} = {8'hCE, 8'h1E, 9'h0A0, 9'h050};
    {sync_lvl_ch2, sync_lvl_ch3, onoff_hyst} = {8'hC8, 8'hC8, 8'h14};
    void'($urandom(32'hFCEC));
    repeat (5) @(negedge clk);
    srst = 1'b0;
    use_act = 1'b1;
    startup(1, 1, 0);
    use_act = 1'b0;
    chk("brighten_count", 2, n_up);
    chk("stop_count", 1, n_stop);
    startup(0, 1, 0);
    chk("switch_count", 1, n_sw);
    for (int m = 0; m < 3; m += 2)
    begin
      startup(m, 3, 0);
      chk("switch_count", 0, n_sw + n_up + n_stop);
      chk_vals(180);
    end
    startup(3, 3, 40);
    chk_vals(76);
    startup(2, 3, 150);
    chk("val_count", 0, n_val);
    for (int m = 0; m < 3; m++)
    begin
      ofs_method = 2'(m);
      {ofs_fixed_ch2, ofs_fixed_ch3} = 16'($urandom);
      {ofs_pct_ch2, ofs_pct_ch3} = {9'($urandom_range(300)), 9'($urandom_range(300))};
      {sync_lvl_ch2, sync_lvl_ch3} = {8'($urandom_range(255, 2)), 8'($urandom_range(255, 2))};
      onoff_hyst = 8'($urandom_range(20));
      for (int k = 0; k < 20; k++)
      begin
        @(negedge clk);
        ch1_ctrl = k < 2 ? 8'(k * 255) : 8'($urandom);
        ch1_ctrl_valid = 1'b1;
        @(negedge clk);
        ch1_ctrl_valid = 1'b0;
        for (int t = 0; t < 8 && val_send !== 1'b1; t++)
          @(negedge clk);
        chk("val_send", 1, val_send);
        chk_vals(ch1_ctrl);
      end
    end
    complete_run();
  end

endmodule
